/* File: rtl/aff_pkg.sv */
// constants for the amplifier fault flag and serial format register bank
`default_nettype none

package aff_pkg;

  // ==========================================================
  // control port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // ==========================================================
  // register offsets inside a page
  localparam logic [6:0] OFS_PAGE_SELECT = 7'h00;
  localparam logic [6:0] OFS_FAULT_A = 7'h68;
  localparam logic [6:0] OFS_FAULT_B = 7'h6C;
  localparam logic [6:0] OFS_LOW_POWER = 7'h79;
  localparam logic [6:0] OFS_BOOK_SELECT = 7'h7F;
  localparam logic [6:0] OFS_SERIAL_FORMAT = 7'h01;
  localparam logic [6:0] OFS_SLOT_OFFSET = 7'h03;

  // pages and book that hold the registers
  localparam logic [7:0] BOOK_MAIN = 8'h00;
  localparam logic [7:0] PAGE_FAULTS = 8'h00;
  localparam logic [7:0] PAGE_SERIAL = 8'h01;

  // ==========================================================
  // values after reset
  localparam logic [7:0] RST_PAGE = 8'h01;
  localparam logic [7:0] RST_BOOK = 8'h00;
  localparam logic RST_LOW_POWER = 1'b0;
  localparam logic [2:0] RST_FRAME_FORMAT = 3'h0;
  localparam logic [1:0] RST_WORD_LENGTH = 2'h2;
  localparam logic RST_OUT_RELEASE = 1'b0;
  localparam logic [7:0] RST_SLOT_OFFSET = 8'h00;

  // ==========================================================
  // field positions
  localparam int BIT_OVERCURRENT = 7;
  localparam int BIT_UNDERVOLTAGE = 6;
  localparam int BIT_OVERTEMP = 4;
  localparam int BIT_BROWNOUT = 3;
  localparam int BIT_CLOCK_LOST = 2;
  localparam int BIT_CONV_DONE = 1;
  localparam int BIT_CLOCK_ERR_ONE = 3;
  localparam int BIT_CLOCK_ERR_TWO = 2;
  localparam int BIT_LOW_POWER = 7;
  localparam int FMT_FRAME_MSB = 7;
  localparam int FMT_FRAME_LSB = 5;
  localparam int FMT_LEN_MSB = 4;
  localparam int FMT_LEN_LSB = 3;
  localparam int FMT_RELEASE = 0;

  // implemented bits; the rest read as zero
  localparam logic [7:0] MASK_FAULT_A = 8'hDE;
  localparam logic [7:0] MASK_FAULT_B = 8'h0C;

  // ==========================================================
  // frame format codes
  localparam logic [2:0] FMT_I2S = 3'h0;
  localparam logic [2:0] FMT_DSP = 3'h1;
  localparam logic [2:0] FMT_RIGHT_JUSTIFIED = 3'h2;
  localparam logic [2:0] FMT_LEFT_JUSTIFIED = 3'h3;
  localparam logic [2:0] FMT_MONO_PCM = 3'h4;

  // word length in bit clocks per code
  localparam int CNT_W = 9;
  localparam logic [8:0] LEN_CODE0 = 9'h010;
  localparam logic [8:0] LEN_CODE1 = 9'h014;
  localparam logic [8:0] LEN_CODE2 = 9'h018;
  localparam logic [8:0] LEN_CODE3 = 9'h020;
  localparam logic [8:0] CNT_MAX = 9'h1FF;

endpackage : aff_pkg

`default_nettype wire

/* File: rtl/aff_sticky.sv */
// sticky flag register cleared by a read, with set winning over the clear
`timescale 1ns/1ps
`default_nettype none

module aff_sticky #(
  parameter int W = 8,
  parameter logic [7:0] MASK = 8'hFF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // events and read clear
  input wire logic [W-1:0] set_i,
  input wire logic clr_i,
  // flags
  output logic [W-1:0] flags_o
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // an event in the clearing cycle survives the clear
  assign flags_nxt = ((flags_r & ~{W{clr_i}}) | set_i) & MASK[W-1:0];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

  // ==========================================================
  // checks
  set_wins_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (set_i != '0) |=> ((flags_r & $past(set_i & MASK[W-1:0])) == $past(set_i & MASK[W-1:0])))
    else $error("sticky event lost");
  clear_read_a: assert property (@(posedge clk_i) disable iff (srst_i)
    (clr_i && set_i == '0) |=> (flags_r == '0))
    else $error("sticky flags not cleared by read");

endmodule : aff_sticky

`default_nettype wire

/* File: rtl/aff_regs.sv */
// fault flag, low power, book, page and serial format register bank
// How it works
// - reading either fault register clears all its flags afterwards
// - speaker over-current latches fault A bit 7 until read
// - analog under-voltage latches fault A bit 6 until read
// - die over-temperature latches fault A bit 4 until read
// - brownout latches fault A bit 3 until read
// - clock loss latches fault A bit 2 until read
// - conversion completion latches fault A bit 1 until read
// - clock-error detector one latches fault B bit 3 until read
// - clock-error detector two latches fault B bit 2 until read
// - low-power bit 7 set disables power-on reset and enters low power
// - book selector at 0x7F of page zero takes any value 0 to 255
// - page selector steers later accesses and resets to page 1
// - frame format bits 7-5: I2S, DSP, right, left, mono PCM
// - word length codes 0-3 give 16, 20, 24, 32 bits; reset code 2
// - with release set, data output floats after the frame's data bits
// - slot offset counts from word clock rise, ignored in right-justified
`timescale 1ns/1ps
`default_nettype none

module aff_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register access from the control port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [aff_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [aff_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [aff_pkg::DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // fault events from the detectors
  input wire logic speaker_overcurrent_i,
  input wire logic analog_undervoltage_i,
  input wire logic die_overtemp_i,
  input wire logic brownout_i,
  input wire logic clock_lost_i,
  input wire logic conversion_done_i,
  input wire logic clock_error_one_i,
  input wire logic clock_error_two_i,
  // configuration to the rest of the device
  output logic low_power_o,
  output logic [7:0] book_o,
  output logic [7:0] page_o,
  output logic [2:0] serial_frame_format_o,
  output logic [1:0] serial_word_length_o,
  output logic serial_out_release_o,
  output logic [7:0] serial_slot_offset_o,
  // serial data output timing
  input wire logic bit_tick_i,
  input wire logic word_clk_i,
  input wire logic sdata_i,
  output logic sdout_o,
  output logic sdout_oe_o
);

  // ==========================================================
  // address decode
  wire in_main_book = (book_o == aff_pkg::BOOK_MAIN);
  wire on_fault_page = in_main_book && (page_o == aff_pkg::PAGE_FAULTS);
  wire on_serial_page = in_main_book && (page_o == aff_pkg::PAGE_SERIAL);
  // the page selector sits at offset zero of every page so the host can always leave
  wire hit_page = (reg_addr_i == aff_pkg::OFS_PAGE_SELECT);
  wire hit_book = (page_o == aff_pkg::PAGE_FAULTS) &&
                  (reg_addr_i == aff_pkg::OFS_BOOK_SELECT);
  wire hit_fault_a = on_fault_page && (reg_addr_i == aff_pkg::OFS_FAULT_A);
  wire hit_fault_b = on_fault_page && (reg_addr_i == aff_pkg::OFS_FAULT_B);
  wire hit_low_power = on_fault_page && (reg_addr_i == aff_pkg::OFS_LOW_POWER);
  wire hit_format = on_serial_page && (reg_addr_i == aff_pkg::OFS_SERIAL_FORMAT);
  wire hit_offset = on_serial_page && (reg_addr_i == aff_pkg::OFS_SLOT_OFFSET);

  wire wr_page = reg_wr_i && hit_page;
  wire wr_book = reg_wr_i && hit_book;
  wire wr_low_power = reg_wr_i && hit_low_power;
  wire wr_format = reg_wr_i && hit_format;
  wire wr_offset = reg_wr_i && hit_offset;
  wire rd_fault_a = reg_rd_i && hit_fault_a;
  wire rd_fault_b = reg_rd_i && hit_fault_b;

  // ==========================================================
  // sticky fault flags
  logic [7:0] fault_a_set;
  logic [3:0] fault_b_set;
  logic [7:0] fault_a;
  logic [3:0] fault_b;

  always_comb begin
    fault_a_set = 8'h00;
    fault_a_set[aff_pkg::BIT_OVERCURRENT] = speaker_overcurrent_i;
    fault_a_set[aff_pkg::BIT_UNDERVOLTAGE] = analog_undervoltage_i;
    fault_a_set[aff_pkg::BIT_OVERTEMP] = die_overtemp_i;
    fault_a_set[aff_pkg::BIT_BROWNOUT] = brownout_i;
    fault_a_set[aff_pkg::BIT_CLOCK_LOST] = clock_lost_i;
    fault_a_set[aff_pkg::BIT_CONV_DONE] = conversion_done_i;
    fault_b_set = 4'h0;
    fault_b_set[aff_pkg::BIT_CLOCK_ERR_ONE] = clock_error_one_i;
    fault_b_set[aff_pkg::BIT_CLOCK_ERR_TWO] = clock_error_two_i;
  end

  aff_sticky #(
    .W(8),
    .MASK(aff_pkg::MASK_FAULT_A)
  ) u_fault_a (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(fault_a_set),
    .clr_i(rd_fault_a),
    .flags_o(fault_a)
  );

  aff_sticky #(
    .W(4),
    .MASK(aff_pkg::MASK_FAULT_B)
  ) u_fault_b (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(fault_b_set),
    .clr_i(rd_fault_b),
    .flags_o(fault_b)
  );

  // ==========================================================
  // configuration registers
  logic low_power_r;
  logic [7:0] book_r;
  logic [7:0] page_r;
  logic [2:0] frame_format_r;
  logic [1:0] word_length_r;
  logic out_release_r;
  logic [7:0] slot_offset_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_power_r <= aff_pkg::RST_LOW_POWER;
      book_r <= aff_pkg::RST_BOOK;
      page_r <= aff_pkg::RST_PAGE;
    end else begin
      if (wr_low_power) begin
        low_power_r <= reg_wdata_i[aff_pkg::BIT_LOW_POWER];
      end
      if (wr_book) begin
        book_r <= reg_wdata_i;
      end
      if (wr_page) begin
        page_r <= reg_wdata_i;
      end
    end
  end

  // reserved format bits are not stored, so they read back as zero
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      frame_format_r <= aff_pkg::RST_FRAME_FORMAT;
      word_length_r <= aff_pkg::RST_WORD_LENGTH;
      out_release_r <= aff_pkg::RST_OUT_RELEASE;
      slot_offset_r <= aff_pkg::RST_SLOT_OFFSET;
    end else begin
      if (wr_format) begin
        frame_format_r <= reg_wdata_i[aff_pkg::FMT_FRAME_MSB:aff_pkg::FMT_FRAME_LSB];
        word_length_r <= reg_wdata_i[aff_pkg::FMT_LEN_MSB:aff_pkg::FMT_LEN_LSB];
        out_release_r <= reg_wdata_i[aff_pkg::FMT_RELEASE];
      end
      if (wr_offset) begin
        slot_offset_r <= reg_wdata_i;
      end
    end
  end

  assign low_power_o = low_power_r;
  assign book_o = book_r;
  assign page_o = page_r;
  assign serial_frame_format_o = frame_format_r;
  assign serial_word_length_o = word_length_r;
  assign serial_out_release_o = out_release_r;

  // ==========================================================
  // read path
  wire [7:0] rd_low_power = {low_power_r, 7'h00};
  wire [7:0] rd_format = {frame_format_r, word_length_r, 2'h0, out_release_r};
  wire [7:0] rd_fault_b_word = {4'h0, fault_b};
  wire [7:0] rd_mux =
    hit_page ? page_r :
    hit_book ? book_r :
    hit_fault_a ? fault_a :
    hit_fault_b ? rd_fault_b_word :
    hit_low_power ? rd_low_power :
    hit_format ? rd_format :
    hit_offset ? slot_offset_r :
    8'h00;

  logic [7:0] rdata_r;
  logic rvalid_r;

  // the flags seen by the host are those before the clearing edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= reg_rd_i ? rd_mux : 8'h00;
      rvalid_r <= reg_rd_i;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // ==========================================================
  // slot offset and data window
  wire is_right_justified = (frame_format_r == aff_pkg::FMT_RIGHT_JUSTIFIED);
  // right-justified data is aligned to the frame end, so no offset applies there
  wire [7:0] eff_offset = is_right_justified ? 8'h00 : slot_offset_r;

  logic [8:0] word_bits;
  always_comb begin
    unique case (word_length_r)
      2'h0: word_bits = aff_pkg::LEN_CODE0;
      2'h1: word_bits = aff_pkg::LEN_CODE1;
      2'h2: word_bits = aff_pkg::LEN_CODE2;
      2'h3: word_bits = aff_pkg::LEN_CODE3;
    endcase
  end

  logic word_clk_r;
  logic [aff_pkg::CNT_W-1:0] bit_cnt_r;
  logic [aff_pkg::CNT_W-1:0] bit_cnt_nxt;
  wire word_clk_rise = word_clk_i && !word_clk_r;
  wire [aff_pkg::CNT_W-1:0] data_end = {1'b0, eff_offset} + word_bits;
  wire data_done = (bit_cnt_r >= data_end);
  // counter saturates so a stopped word clock cannot wrap into a new window
  wire cnt_full = (bit_cnt_r == aff_pkg::CNT_MAX);

  assign bit_cnt_nxt = word_clk_rise ? '0 :
                       (bit_tick_i && !cnt_full) ? bit_cnt_r + 9'h001 :
                       bit_cnt_r;

  logic [7:0] slot_offset_q;
  logic sdout_r;
  logic sdout_oe_r;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      word_clk_r <= 1'b0;
      bit_cnt_r <= aff_pkg::CNT_MAX;
      slot_offset_q <= 8'h00;
      sdout_r <= 1'b0;
      sdout_oe_r <= 1'b0;
    end else begin
      word_clk_r <= word_clk_i;
      bit_cnt_r <= bit_cnt_nxt;
      slot_offset_q <= eff_offset;
      sdout_r <= sdata_i;
      sdout_oe_r <= !(out_release_r && data_done);
    end
  end

  assign serial_slot_offset_o = slot_offset_q;
  assign sdout_o = sdout_r;
  assign sdout_oe_o = sdout_oe_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  sequence s_fault_a_read;
    rd_fault_a && (fault_a_set == 8'h00);
  endsequence

  sequence s_format_write;
    wr_format ##1 !wr_format;
  endsequence

  fault_a_clear_a: assert property (s_fault_a_read |=> (fault_a == 8'h00))
    else $error("fault A not cleared by read");
  fault_b_clear_a: assert property ((rd_fault_b && fault_b_set == 4'h0) |=>
    (fault_b == 4'h0))
    else $error("fault B not cleared by read");
  overcurrent_hold_a: assert property ((speaker_overcurrent_i ##1 !rd_fault_a) |=>
    fault_a[aff_pkg::BIT_OVERCURRENT])
    else $error("over-current flag not held");
  undervolt_latch_a: assert property (analog_undervoltage_i |=>
    fault_a[aff_pkg::BIT_UNDERVOLTAGE])
    else $error("under-voltage flag not latched");
  overtemp_latch_a: assert property (die_overtemp_i |=> fault_a[aff_pkg::BIT_OVERTEMP])
    else $error("over-temperature flag not latched");
  brownout_latch_a: assert property (brownout_i |=> fault_a[aff_pkg::BIT_BROWNOUT])
    else $error("brownout flag not latched");
  clock_lost_latch_a: assert property (clock_lost_i |=> fault_a[aff_pkg::BIT_CLOCK_LOST])
    else $error("clock loss flag not latched");
  conv_done_latch_a: assert property (conversion_done_i |=>
    fault_a[aff_pkg::BIT_CONV_DONE])
    else $error("conversion flag not latched");
  clock_err_one_a: assert property (clock_error_one_i |=>
    fault_b[aff_pkg::BIT_CLOCK_ERR_ONE])
    else $error("clock error one flag not latched");
  clock_err_two_a: assert property (clock_error_two_i |=>
    fault_b[aff_pkg::BIT_CLOCK_ERR_TWO])
    else $error("clock error two flag not latched");
  fault_read_data_a: assert property (rd_fault_a |=>
    (reg_rvalid_o && reg_rdata_o == $past(fault_a)))
    else $error("fault A read data wrong");
  low_power_write_a: assert property (wr_low_power |=>
    (low_power_o == $past(reg_wdata_i[aff_pkg::BIT_LOW_POWER])))
    else $error("low power bit not written");
  book_write_a: assert property (wr_book |=> (book_o == $past(reg_wdata_i)))
    else $error("book selector not written");
  page_steer_a: assert property ((wr_page && reg_wdata_i != aff_pkg::PAGE_SERIAL) |=>
    !hit_format)
    else $error("format reachable off its page");
  format_write_a: assert property (s_format_write |->
    (serial_frame_format_o == $past(reg_wdata_i[aff_pkg::FMT_FRAME_MSB:aff_pkg::FMT_FRAME_LSB])))
    else $error("frame format not written");
  len_write_a: assert property (wr_format |=>
    (serial_word_length_o == $past(reg_wdata_i[aff_pkg::FMT_LEN_MSB:aff_pkg::FMT_LEN_LSB])))
    else $error("word length not written");
  page_write_a: assert property (wr_page |=> (page_o == $past(reg_wdata_i)))
    else $error("page selector not written");
  offset_apply_a: assert property (!is_right_justified |=>
    (serial_slot_offset_o == $past(slot_offset_r)))
    else $error("slot offset not applied");
  reserved_zero_a: assert property ((reg_rd_i && hit_fault_a) |=>
    (reg_rdata_o[5] == 1'b0 && reg_rdata_o[0] == 1'b0))
    else $error("reserved fault bits read non-zero");
  release_float_a: assert property ((out_release_r && data_done) |=> !sdout_oe_o)
    else $error("data output not released after data");
  drive_no_release_a: assert property (!out_release_r |=> sdout_oe_o)
    else $error("data output released while disabled");
  rjf_no_offset_a: assert property (is_right_justified |=>
    (serial_slot_offset_o == 8'h00))
    else $error("offset applied in right-justified mode");
  frame_start_a: assert property (word_clk_rise |=> (bit_cnt_r == '0))
    else $error("slot count not restarted at word clock rise");
  len_reset_a: assert property ($fell(srst_i) && !$past(wr_format) |->
    (serial_word_length_o == aff_pkg::RST_WORD_LENGTH))
    else $error("word length reset value wrong");

endmodule : aff_regs

`default_nettype wire

/* File: verif/aff_host.sv */
// host processor model that issues single byte register accesses
`timescale 1ns/1ps
`default_nettype none

module aff_host (
  // clock
  input wire logic clk_i,
  // register access toward the bank
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [aff_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [aff_pkg::DATA_W-1:0] reg_wdata_o,
  input wire logic [aff_pkg::DATA_W-1:0] reg_rdata_i,
  input wire logic reg_rvalid_i
);
  // ==========================================================
  // idle state
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end

  // ==========================================================
  // one access at a time; read and write strobes never overlap
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    reg_wdata_o <= d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // released buses show a changed value so stale data cannot pass
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask : wr_reg

  task automatic rd_reg(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    // answer stands for one cycle only, so take it mid-cycle
    @(negedge clk_i);
    d = reg_rdata_i;
    ok = reg_rvalid_i;
  endtask : rd_reg

endmodule : aff_host

`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking testbench for the fault flag and serial format register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  // ==========================================================
  // signals
  logic clk_i;
  logic srst_i;
  logic [7:0] ev;
  logic bit_tick;
  logic word_clk;
  logic sdata;
  logic reg_wr;
  logic reg_rd;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  logic low_power;
  logic [7:0] book;
  logic [7:0] page;
  logic [2:0] frame_fmt;
  logic [1:0] word_len;
  logic out_rel;
  logic [7:0] slot_ofs;
  logic sdout;
  logic sdout_oe;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // ==========================================================
  // design and host
  aff_regs uut (
    .clk_i(clk_i), .srst_i(srst_i),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
    .speaker_overcurrent_i(ev[0]), .analog_undervoltage_i(ev[1]),
    .die_overtemp_i(ev[2]), .brownout_i(ev[3]), .clock_lost_i(ev[4]),
    .conversion_done_i(ev[5]), .clock_error_one_i(ev[6]), .clock_error_two_i(ev[7]),
    .low_power_o(low_power), .book_o(book), .page_o(page),
    .serial_frame_format_o(frame_fmt), .serial_word_length_o(word_len),
    .serial_out_release_o(out_rel), .serial_slot_offset_o(slot_ofs),
    .bit_tick_i(bit_tick), .word_clk_i(word_clk), .sdata_i(sdata),
    .sdout_o(sdout), .sdout_oe_o(sdout_oe)
  );

  aff_host host (
    .clk_i(clk_i), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata), .reg_rvalid_i(reg_rvalid)
  );

  // ==========================================================
  // shared helpers
  task automatic finish_test();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rd_reg(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rd_chk

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    ev <= m;
    @(posedge clk_i);
    ev <= 8'h00;
  endtask : pulse

  task automatic ticks(input int n);
    @(posedge clk_i);
    bit_tick <= 1'b1;
    repeat (n) @(posedge clk_i);
    bit_tick <= 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask : ticks

  // ==========================================================
  // scenarios
  task automatic test_reset();
    @(negedge clk_i);
    chk(page, 8'h01);
    chk(book, 8'h00);
    chk({7'h00, low_power}, 8'h00);
    chk({6'h00, word_len}, 8'h02);
    rd_chk(aff_pkg::OFS_PAGE_SELECT, 8'h01);
    rd_chk(aff_pkg::OFS_SERIAL_FORMAT, 8'h10);
    $display("test reset done");
  endtask : test_reset

  task automatic test_faults();
    logic [7:0] masks [8];
    logic [6:0] adr;
    masks = '{8'h80, 8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h08, 8'h04};
    host.wr_reg(aff_pkg::OFS_PAGE_SELECT, 8'h00);
    rd_chk(aff_pkg::OFS_FAULT_A, 8'h00);
    for (int i = 0; i < 8; i++) begin
      adr = (i < 6) ? aff_pkg::OFS_FAULT_A : aff_pkg::OFS_FAULT_B;
      pulse(8'h01 << i);
      repeat (4) @(posedge clk_i);
      rd_chk(adr, masks[i]);
      rd_chk(adr, 8'h00);
    end
    pulse(8'hFF);
    host.wr_reg(aff_pkg::OFS_FAULT_B, 8'h00);
    rd_chk(aff_pkg::OFS_FAULT_A, 8'hDE);
    rd_chk(aff_pkg::OFS_FAULT_B, 8'h0C);
    rd_chk(aff_pkg::OFS_FAULT_A, 8'h00);
    rd_chk(aff_pkg::OFS_FAULT_B, 8'h00);
    $display("test faults done");
  endtask : test_faults

  task automatic test_low_power_book();
    logic [7:0] vals [3];
    vals = '{8'hFF, 8'hA5, 8'h00};
    host.wr_reg(aff_pkg::OFS_LOW_POWER, 8'hFF);
    @(negedge clk_i);
    chk({7'h00, low_power}, 8'h01);
    rd_chk(aff_pkg::OFS_LOW_POWER, 8'h80);
    host.wr_reg(aff_pkg::OFS_LOW_POWER, 8'h7F);
    @(negedge clk_i);
    chk({7'h00, low_power}, 8'h00);
    rd_chk(aff_pkg::OFS_LOW_POWER, 8'h00);
    rd_chk(7'h10, 8'h00);
    for (int i = 0; i < 3; i++) begin
      host.wr_reg(aff_pkg::OFS_BOOK_SELECT, vals[i]);
      @(negedge clk_i);
      chk(book, vals[i]);
      rd_chk(aff_pkg::OFS_BOOK_SELECT, vals[i]);
    end
    $display("test low power and book done");
  endtask : test_low_power_book

  task automatic test_format();
    host.wr_reg(aff_pkg::OFS_PAGE_SELECT, 8'h01);
    @(negedge clk_i);
    chk(page, 8'h01);
    for (int f = 0; f < 5; f++) begin
      host.wr_reg(aff_pkg::OFS_SERIAL_FORMAT, {f[2:0], f[1:0], 3'h7});
      @(negedge clk_i);
      chk({5'h00, frame_fmt}, {5'h00, f[2:0]});
      chk({6'h00, word_len}, {6'h00, f[1:0]});
      chk({7'h00, out_rel}, 8'h01);
      rd_chk(aff_pkg::OFS_SERIAL_FORMAT, {f[2:0], f[1:0], 3'h1});
    end
    $display("test format done");
  endtask : test_format

  task automatic test_serial();
    // non-zero offset goes with left-justified, never right-justified
    host.wr_reg(aff_pkg::OFS_SLOT_OFFSET, 8'h02);
    host.wr_reg(aff_pkg::OFS_SERIAL_FORMAT, 8'h61);
    @(negedge clk_i);
    chk(slot_ofs, 8'h02);
    chk({7'h00, sdout_oe}, 8'h00);
    @(posedge clk_i);
    word_clk <= 1'b1;
    sdata <= 1'b1;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk({7'h00, sdout_oe}, 8'h01);
    chk({7'h00, sdout}, 8'h01);
    // offset 2 plus 16 bits: still driving after 17 bit clocks
    ticks(17);
    chk({7'h00, sdout_oe}, 8'h01);
    ticks(1);
    chk({7'h00, sdout_oe}, 8'h00);
    @(posedge clk_i);
    word_clk <= 1'b0;
    sdata <= 1'b0;
    host.wr_reg(aff_pkg::OFS_SERIAL_FORMAT, 8'h40);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk(slot_ofs, 8'h00);
    chk({7'h00, sdout_oe}, 8'h01);
    chk({7'h00, sdout}, 8'h00);
    $display("test serial done");
  endtask : test_serial

  // ==========================================================
  // main sequence
  initial begin
    srst_i = 1'b1;
    ev = 8'h00;
    bit_tick = 1'b0;
    word_clk = 1'b0;
    sdata = 1'b0;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    test_reset();
    test_faults();
    test_low_power_book();
    test_format();
    test_serial();
    finish_test();
  end

endmodule : tb_top

`default_nettype wire
